// *** hdl/add_bus_line_consts.vh ***
// Behaviour
// - The shared input feeds the channel 3 add data bus when that bus is enabled, otherwise it is the channel 11 line clock.
// - In bus mode the shared input is captured with add data bits 6..0 on each falling edge of the add bus clock.
// - The source drives the shared input as bit 7 of the add byte and the device places it in the most significant bit.
// - In line mode the recovered clock captures the channel 11 line data, on its falling edge by default.
// - For DS3/E3 the capture moves to the rising edge when the clock invert bit, bit 1 of the channel 11 I/O control register, is one.
// - For STS-1 the capture always stays on the falling edge whatever the invert bit says.
`ifndef ADD_BUS_LINE_CONSTS_VH
`define ADD_BUS_LINE_CONSTS_VH
// ---------------------------------------------------------------
// Register map (byte addresses, plus the channel 11 I/O control word index)
// ---------------------------------------------------------------
`define LINE_IO_CTRL_CH11_IDX  16'hcf01
`define LINE_IO_CTRL_CH11_ADDR 18'h33c04
`define MODE_CTRL_ADDR         18'h00000
`define STATUS_ADDR            18'h00004
`define ADD_DATA_ADDR          18'h00008
`define LINE_DATA_ADDR         18'h0000c
// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define CLK_INV_BIT            1
`define MODE_BUS_EN_BIT        0
`define MODE_STS1_BIT          1
`define LINE_IO_CTRL_RESET     8'h00
`define MODE_CTRL_RESET        2'h0
`define ADDR_W                 18
`endif

// *** hdl/sync_edge.v ***
`timescale 1ns/10ps
// Two-flop synchroniser with rise and fall pulses
module sync_edge
(
  input  wire pclk,     // System clock
  input  wire presetn,  // Async reset, active low
  input  wire async_in, // Input from outside domain
  output wire level,    // Synchronised level
  output wire rise,     // One-cycle rising edge pulse
  output wire fall      // One-cycle falling edge pulse
);
  reg s1;
  reg s2;
  reg s3;
  reg [2:0] warm;

  // ---------------------------------------------------------------
  // Synchroniser and edge history
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Edges held off until the history flop holds a real pin sample, so no false edge after reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      warm <= 3'h0;
    else
      warm <= {warm[1:0], 1'b1};
  end

  assign level = s2;
  assign rise  = s2 & ~s3 & warm[2];
  assign fall  = ~s2 & s3 & warm[2];
endmodule // sync_edge

// *** hdl/add_bus_bit_line_clock_select.v ***
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "add_bus_line_consts.vh"
// Shared input routing between channel 3 add bus bit 7 and channel 11 line clock
module add_bus_bit_line_clock_select
(
  input  wire        pclk,                // APB clock, 125 MHz
  input  wire        presetn,             // Async reset, active low
  input  wire        psel,                // APB select
  input  wire        penable,             // APB enable
  input  wire        pwrite,              // APB direction
  input  wire [17:0] paddr,               // APB byte address
  input  wire [31:0] pwdata,              // APB write data
  output reg  [31:0] prdata,              // APB read data
  output wire        pready,              // APB ready
  output wire        pslverr,             // APB error
  input  wire        shared_input_bit7,   // Shared pin
  input  wire        add_bus_ch3_clock,   // Add bus clock
  input  wire [6:0]  add_bus_ch3_data_lo, // Add data bits 6..0
  input  wire        line_data_in_ch11,   // Channel 11 line data
  output reg  [7:0]  add_bus_ch3_byte,    // Captured add byte
  output reg         add_bus_ch3_valid,   // Add byte strobe
  output reg         line_bit_ch11,       // Captured line bit
  output reg         line_bit_valid       // Line bit strobe
);
  reg  [7:0] line_io_control_ch11;
  reg  [1:0] mode_ctrl;
  reg  [6:0] lo_s1;
  reg  [6:0] lo_s2;
  reg  [6:0] lo_s3;
  reg        ld_s1;
  reg        ld_s2;
  reg        ld_s3;
  reg        sh_d;
  reg        next_line_bit_valid;
  reg [31:0] next_prdata;
  wire       bus_en;
  wire       use_rise;
  wire       bclk_fall;
  wire       lclk_rise;
  wire       lclk_fall;
  wire       sh_level;
  wire       sh_rise;
  wire       sh_fall;
  wire       wr;
  wire       rd_ok;

  // ---------------------------------------------------------------
  // Synchronisers and edge finders
  // ---------------------------------------------------------------
  sync_edge u_bclk
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (add_bus_ch3_clock),
    .level    (),
    .rise     (),
    .fall     (bclk_fall)
  );

  sync_edge u_shared
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (shared_input_bit7),
    .level    (sh_level),
    .rise     (sh_rise),
    .fall     (sh_fall)
  );

  // Data bits delayed to match the edge detector, so all eight bits share one sample
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_s1 <= 7'h00;
      lo_s2 <= 7'h00;
      lo_s3 <= 7'h00;
      ld_s1 <= 1'b0;
      ld_s2 <= 1'b0;
      ld_s3 <= 1'b0;
      sh_d  <= 1'b0;
    end
    else
    begin
      sh_d  <= sh_level;
      lo_s1 <= add_bus_ch3_data_lo;
      lo_s2 <= lo_s1;
      lo_s3 <= lo_s2;
      ld_s1 <= line_data_in_ch11;
      ld_s2 <= ld_s1;
      ld_s3 <= ld_s2;
    end
  end

  // Mode selection
  assign bus_en    = mode_ctrl[`MODE_BUS_EN_BIT];
  assign lclk_rise = ~bus_en & sh_rise;
  assign lclk_fall = ~bus_en & sh_fall;
  assign use_rise  = line_io_control_ch11[`CLK_INV_BIT]
                     & ~mode_ctrl[`MODE_STS1_BIT];

  // ---------------------------------------------------------------
  // Capture paths
  // ---------------------------------------------------------------
  always @*
  begin
    next_line_bit_valid = use_rise ? lclk_rise : lclk_fall;
  end

  // Add byte on bus clock fall, line bit on selected line clock edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      add_bus_ch3_byte  <= 8'h00;
      add_bus_ch3_valid <= 1'b0;
      line_bit_ch11     <= 1'b0;
      line_bit_valid    <= 1'b0;
    end
    else
    begin
      add_bus_ch3_valid <= bus_en & bclk_fall;
      if (bus_en && bclk_fall)
        add_bus_ch3_byte <= {sh_d, lo_s3};
      line_bit_valid <= next_line_bit_valid;
      if (next_line_bit_valid)
        line_bit_ch11 <= ld_s3;
    end
  end

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd_ok   = (paddr == `LINE_IO_CTRL_CH11_ADDR) | (paddr == `MODE_CTRL_ADDR) |
                   (paddr == `STATUS_ADDR) | (paddr == `ADD_DATA_ADDR) |
                   (paddr == `LINE_DATA_ADDR);
  assign pslverr = psel & penable & ~rd_ok;

  // Register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_io_control_ch11 <= `LINE_IO_CTRL_RESET;
      mode_ctrl            <= `MODE_CTRL_RESET;
    end
    else if (wr)
    begin
      if (paddr == `LINE_IO_CTRL_CH11_ADDR)
        line_io_control_ch11 <= pwdata[7:0];
      if (paddr == `MODE_CTRL_ADDR)
        mode_ctrl <= pwdata[1:0];
    end
  end

  // Read mux
  always @*
  begin
    case (paddr)
      `LINE_IO_CTRL_CH11_ADDR: next_prdata = {24'h000000, line_io_control_ch11};
      `MODE_CTRL_ADDR:         next_prdata = {30'h0, mode_ctrl};
      `STATUS_ADDR:            next_prdata = {29'h0, use_rise, sh_level, bus_en};
      `ADD_DATA_ADDR:          next_prdata = {24'h000000, add_bus_ch3_byte};
      `LINE_DATA_ADDR:         next_prdata = {31'h0, line_bit_ch11};
      default:                 next_prdata = 32'h00000000;
    endcase
  end

  // Read data taken in the setup cycle and held through the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end
endmodule // add_bus_bit_line_clock_select

// *** tb/abls_chk_assertions.sv ***
`timescale 1ns/10ps
// Strobe, edge and data checks on the capture outputs
module abls_chk
(
  input wire       pclk,                // Clock
  input wire       presetn,             // Reset
  input wire       shared_input_bit7,   // Shared pin
  input wire       add_bus_ch3_clock,   // Add clock
  input wire [6:0] add_bus_ch3_data_lo, // Add bits
  input wire       line_data_in_ch11,   // Line data
  input wire [7:0] add_bus_ch3_byte,    // Add byte
  input wire       add_bus_ch3_valid,   // Add strobe
  input wire       line_bit_ch11,       // Line bit
  input wire       line_bit_valid       // Line strobe
);
  wire av = add_bus_ch3_valid;
  wire lv = line_bit_valid;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One path at a time, one-cycle strobes, pin values from the capture edge
  a_one_path: assert property (!(av && lv)) else $error("two strobes");
  a_add_pulse: assert property (av |=> !av) else $error("add strobe");
  a_add_fall: assert property (av |-> $past(add_bus_ch3_clock, 4) && !$past(add_bus_ch3_clock, 3))
    else $error("edge");
  a_add_low: assert property (av |-> add_bus_ch3_byte[6:0] == $past(add_bus_ch3_data_lo, 4))
    else $error("low bits");
  a_add_msb: assert property (av |-> add_bus_ch3_byte[7] == $past(shared_input_bit7, 4))
    else $error("top bit");
  a_line_pulse: assert property (lv |=> !lv) else $error("line strobe");
  a_line_data: assert property (lv |-> line_bit_ch11 == $past(line_data_in_ch11, 4))
    else $error("line bit");
  a_line_edge: assert property (lv |-> $past(shared_input_bit7, 4) != $past(shared_input_bit7, 3))
    else $error("no line edge");
endmodule // abls_chk
bind add_bus_bit_line_clock_select abls_chk chk_u (.*);

// *** tb/link_source.sv ***
`timescale 1ns/10ps
// Add bus source when the bus is enabled, line interface unit otherwise
module link_source
(
  input  wire       run,  // Frames on
  input  wire       bus,  // Add bus mode
  input  wire       rise, // Rising capture
  output reg        aclk, // Add clock
  output reg        sh,   // Shared pin
  output reg  [6:0] lo,       // Add bits
  output reg        ld,       // Line data
  output reg  [7:0] note,     // Expected result of this pass
  output reg [15:0] note_cnt  // Counts notes
);
  integer seed = 24;
  reg [7:0] d;
  // Idle levels: both clocks high
  initial
  begin
    {aclk, sh, lo, ld} = 10'h300;
    note     = 8'h00;
    note_cnt = 16'h0000;
  end
  // One 160 ns period a pass; clocks stand still while run is low
  always
  begin
    wait (run);
    d = 8'($random(seed));
    note = bus ? d : {7'h00, d[rise]};
    note_cnt = note_cnt + 16'h0001;
    lo <= d[6:0];
    ld <= d[0];
    if (bus) sh <= d[7];
    #40 if (!bus) sh <= 1'b0;
    #40 aclk <= 1'b0;
    ld <= d[1];
    #40 if (!bus) sh <= 1'b1;
    #40 aclk <= 1'b1;
  end
endmodule // link_source

// *** tb/add_bus_bit_line_clock_select_tb.sv ***
`timescale 1ns/10ps
`include "add_bus_line_consts.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: mismatch", $time); end end
module add_bus_bit_line_clock_select_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, bus = 0, rise = 0;
  reg [17:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, shared_input_bit7, add_bus_ch3_clock, line_data_in_ch11;
  wire add_bus_ch3_valid, line_bit_ch11, line_bit_valid;
  wire [6:0] add_bus_ch3_data_lo;
  wire [7:0] add_bus_ch3_byte;
  wire [7:0] got = add_bus_ch3_valid ? add_bus_ch3_byte : {7'h0, line_bit_ch11};
  logic [7:0] q[$];
  integer error_cnt = 0, check_count = 0, cyc = 0;
  reg [7:0] last_add = 8'h00, exp_v = 8'h00;
  reg last_line = 1'b0;
  reg [31:0] st_exp = 32'h00000000;
  wire [7:0] note;
  wire [15:0] note_cnt;
  // Clock and the two parties
  always #4 pclk = ~pclk;
  add_bus_bit_line_clock_select dut_u (.*);
  link_source src_u (.run, .bus, .rise, .aclk(add_bus_ch3_clock), .sh(shared_input_bit7),
    .lo(add_bus_ch3_data_lo), .ld(line_data_in_ch11), .note(note), .note_cnt(note_cnt));
  // The source notes each pass's expected result
  always @(note_cnt) if (note_cnt != 16'h0000) q.push_back(note);
  // Each strobe takes the oldest note; an unannounced one fails
  always @(negedge pclk) if (add_bus_ch3_valid | line_bit_valid)
  begin
    exp_v = q.size() ? q.pop_front() : 8'hxx;
    `CHK(got, exp_v)
    if (add_bus_ch3_valid) last_add = exp_v;
    else last_line = exp_v[0];
  end
  // Hang guard
  always @(posedge pclk) if (++cyc == 5000) begin error_cnt++; stop_test; end
  task apb(input logic w, input logic [17:0] a, input logic [31:0] wd, ex, input logic er);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) `CHK(prdata, ex)
    `CHK(pslverr, er)
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Line falling, line rising, STS-1 with invert set, then add bus
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `LINE_IO_CTRL_CH11_ADDR, 0, 0, 0);
    apb(0, `MODE_CTRL_ADDR, 0, 0, 0);
    apb(0, 18'h00010, 0, 0, 1);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 1) apb(1, `LINE_IO_CTRL_CH11_ADDR, 2, 0, 0);
      if (i == 1) apb(0, `LINE_IO_CTRL_CH11_ADDR, 0, 2, 0);
      if (i > 1) apb(1, `MODE_CTRL_ADDR, 4 - i, 0, 0);
      if (i > 1) apb(0, `MODE_CTRL_ADDR, 0, 4 - i, 0);
      {bus, rise, run} <= {i == 3, i == 1, 1'b1};
      repeat (160) @(posedge pclk);
      run <= 0;
      repeat (60) @(posedge pclk);
      st_exp = {29'h0, (i == 1 || i == 3), shared_input_bit7, i == 3};
      apb(0, `STATUS_ADDR, 0, st_exp, 0);
      if (i == 3) apb(0, `ADD_DATA_ADDR, 0, {24'h0, last_add}, 0);
      else apb(0, `LINE_DATA_ADDR, 0, {31'h0, last_line}, 0);
    end
    `CHK(q.size(), 0)
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `LINE_IO_CTRL_CH11_ADDR, 0, 0, 0);
    apb(0, `MODE_CTRL_ADDR, 0, 0, 0);
    stop_test;
  end
endmodule // add_bus_bit_line_clock_select_tb
